//--- hdl/amp_regs_pkg.sv
package amp_regs_pkg;
    localparam logic [7:0] ADDR_ID       = 8'h01;
    localparam logic [7:0] ADDR_ERR      = 8'h02;
    localparam logic [7:0] ADDR_SYS1     = 8'h03;
    localparam logic [7:0] ADDR_FMT      = 8'h04;
    localparam logic [7:0] ADDR_SYS2     = 8'h05;
    localparam logic [7:0] ADDR_MUTE     = 8'h06;
    // identification value is arbitrary
    localparam logic [7:0] ID_VALUE      = 8'h5a;
    localparam logic [7:0] ERR_RESET     = 8'h00;
    localparam logic [7:0] SYS1_RESET    = 8'h80;
    localparam logic [7:0] FMT_RESET     = 8'h05;
    localparam logic [7:0] SYS2_RESET    = 8'h40;
    localparam logic [7:0] MUTE_RESET    = 8'h00;
    localparam logic [7:0] SYS1_MASK     = 8'ha3;
    localparam logic [7:0] SYS2_MASK     = 8'hca;
    localparam logic [7:0] MUTE_MASK     = 8'h07;
    localparam logic [7:0] ERR_MASK      = 8'hfe;
    localparam int         BIT_MCLK      = 7;
    localparam int         BIT_PLL       = 6;
    localparam int         BIT_SCLK      = 5;
    localparam int         BIT_LRCLK     = 4;
    localparam int         BIT_SLIP      = 3;
    localparam int         BIT_CLIP      = 2;
    localparam int         BIT_PROT      = 1;
    localparam int         BIT_DCBLOCK   = 7;
    localparam int         BIT_HARDUNM   = 5;
    localparam int         BIT_SHUTDOWN  = 6;
    localparam int         BIT_TERNARY   = 3;
    localparam int         BIT_FAULTDIR  = 1;
    localparam logic [3:0] FMT_LAST      = 4'h8;
    localparam int         NUM_CH        = 3;
    localparam logic [11:0] RAMP_STEPS   = 12'h0200;
    localparam logic [3:0] PWM_PERIOD    = 4'h8;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       dc_block;
        logic       hard_unmute;
        logic [1:0] deemph;
        logic [3:0] fmt;
        logic       shutdown;
        logic       ternary;
        logic       fault_out;
    } ctrl_t;
endpackage

//--- hdl/clock_monitor.sv
module clock_monitor
    import amp_regs_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic frame_tick,
    input  wire logic count_tick,
    input  wire logic sync_tick,
    output logic      count_err,
    output logic      period_err,
    output logic      slip_err
);
    logic [15:0] cnt_q;
    logic [15:0] last_q;
    logic        seen_q;
    logic [7:0]  frm_q;
    logic [7:0]  frm_last_q;
    logic        frm_seen_q;

    // counts events per frame; a change in count marks a fault
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            cnt_q <= 16'h0000;
            last_q <= 16'h0000;
            seen_q <= 1'b0;
            count_err <= 1'b0;
        end
        else
        begin
            count_err <= 1'b0;
            if (frame_tick)
            begin
                cnt_q <= 16'(count_tick);
                last_q <= cnt_q;
                seen_q <= 1'b1;
                count_err <= seen_q && (cnt_q != last_q);
            end
            else if (count_tick)
                cnt_q <= cnt_q + 16'h0001;
        end
    end

    // frame period in core cycles; the internal sync must land on frame edges
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            frm_q <= 8'h00;
            frm_last_q <= 8'h00;
            frm_seen_q <= 1'b0;
            period_err <= 1'b0;
            slip_err <= 1'b0;
        end
        else
        begin
            period_err <= 1'b0;
            slip_err <= frm_seen_q && (sync_tick != frame_tick);
            if (frame_tick)
            begin
                frm_q <= 8'h00;
                frm_last_q <= frm_q;
                frm_seen_q <= 1'b1;
                period_err <= frm_seen_q && (frm_q != frm_last_q) && (frm_last_q != 8'h00);
            end
            else if (frm_q != 8'hff)
                frm_q <= frm_q + 8'h01;
        end
    end
endmodule

//--- hdl/amp_control_status_regs.sv
module amp_control_status_regs
    import amp_regs_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             reg_en,
    input  wire reg_req_t         reg_req,
    output logic [7:0]            reg_rdata,
    input  wire logic             mclk_pin,
    input  wire logic             sclk_pin,
    input  wire logic             lrclk_pin,
    input  wire logic             pll_unlock,
    input  wire logic             clip_event,
    input  wire logic             protect_event,
    input  wire logic             clock_error,
    input  wire logic             fault_pin_in,
    output logic                  fault_pin_out,
    output logic                  fault_pin_oe_n,
    output ctrl_t                 ctrl,
    output logic [7:0]            volume_scale,
    output logic [NUM_CH-1:0]     mute_pwm
);
    logic [2:0]  mclk_s_q;
    logic [2:0]  sclk_s_q;
    logic [2:0]  lr_s_q;
    logic        mclk_rise;
    logic        sclk_rise;
    logic        lr_rise;
    logic        sync_tick;
    logic        mclk_err;
    logic        sclk_err;
    logic        lr_err;
    logic        lr_err_unused;
    logic        slip_err;
    logic        slip_unused;
    logic        mclk_unused;
    logic [7:0]  err_q;
    logic [7:0]  err_set;
    logic [7:0]  sys1_q;
    logic [7:0]  fmt_q;
    logic [7:0]  sys2_q;
    logic [7:0]  mute_q;
    logic [11:0] ramp_q;
    logic [3:0]  pwm_q;
    logic [7:0]  lr_cnt_q;
    logic [7:0]  lr_per_q;
    logic        lr_armed_q;

    function automatic logic wr_hit(input reg_req_t r, input logic en, input logic [7:0] a);
        wr_hit = en && r.wr && (r.addr == a);
    endfunction

    // pins are asynchronous: two flops before the edge detectors look
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            mclk_s_q <= 3'h0;
            sclk_s_q <= 3'h0;
            lr_s_q <= 3'h0;
        end
        else
        begin
            mclk_s_q <= {mclk_s_q[1:0], mclk_pin};
            sclk_s_q <= {sclk_s_q[1:0], sclk_pin};
            lr_s_q <= {lr_s_q[1:0], lrclk_pin};
        end
    end

    assign mclk_rise = mclk_s_q[1] && !mclk_s_q[2];
    assign sclk_rise = sclk_s_q[1] && !sclk_s_q[2];
    assign lr_rise = lr_s_q[1] && !lr_s_q[2];

    // internal frame sync free-runs on the learnt frame period
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            lr_cnt_q <= 8'h00;
            lr_per_q <= 8'h00;
            lr_armed_q <= 1'b0;
        end
        else if (lr_rise && lr_per_q == 8'h00)
        begin
            // first edge only starts the count; the second one gives a whole period
            lr_armed_q <= 1'b1;
            if (lr_armed_q)
                lr_per_q <= lr_cnt_q;
            lr_cnt_q <= 8'h00;
        end
        else if (lr_cnt_q == lr_per_q && lr_per_q != 8'h00)
            lr_cnt_q <= 8'h00;
        else
            lr_cnt_q <= lr_cnt_q + 8'h01;
    end
    // until a period is learnt the sync follows the frame edge, so no false slip
    assign sync_tick = (lr_per_q == 8'h00) ? lr_rise : (lr_cnt_q == lr_per_q);

    // limitation: master clock must not exceed half the core rate to be seen
    clock_monitor u_mclk_mon (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .frame_tick (lr_rise),
        .count_tick (mclk_rise),
        .sync_tick  (sync_tick),
        .count_err  (mclk_err),
        .period_err (lr_err),
        .slip_err   (slip_err)
    );

    clock_monitor u_sclk_mon (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .frame_tick (lr_rise),
        .count_tick (sclk_rise),
        .sync_tick  (sync_tick),
        .count_err  (sclk_err),
        .period_err (lr_err_unused),
        .slip_err   (slip_unused)
    );
    assign mclk_unused = lr_err_unused ^ slip_unused;

    always_comb
    begin
        err_set = 8'h00;
        err_set[BIT_MCLK] = mclk_err;
        err_set[BIT_SCLK] = sclk_err;
        err_set[BIT_LRCLK] = lr_err;
        err_set[BIT_SLIP] = slip_err;
        err_set[BIT_PLL] = pll_unlock;
        err_set[BIT_CLIP] = clip_event;
        err_set[BIT_PROT] = protect_event;
    end

    // set wins over a host write; only the host ever lowers a bit
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            err_q <= ERR_RESET;
        else if (wr_hit(reg_req, reg_en, ADDR_ERR))
            err_q <= ((reg_req.wdata & err_q) | err_set) & ERR_MASK;
        else
            err_q <= (err_q | err_set) & ERR_MASK;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            sys1_q <= SYS1_RESET;
            fmt_q <= FMT_RESET;
            sys2_q <= SYS2_RESET;
            mute_q <= MUTE_RESET;
        end
        else
        begin
            if (wr_hit(reg_req, reg_en, ADDR_SYS1))
                sys1_q <= reg_req.wdata & SYS1_MASK;
            // reserved codes are dropped so the framer never sees them
            if (wr_hit(reg_req, reg_en, ADDR_FMT) && reg_req.wdata <= {4'h0, FMT_LAST})
                fmt_q <= reg_req.wdata;
            if (wr_hit(reg_req, reg_en, ADDR_SYS2))
                sys2_q <= reg_req.wdata & SYS2_MASK;
            if (wr_hit(reg_req, reg_en, ADDR_MUTE))
                mute_q <= reg_req.wdata & MUTE_MASK;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_en && !reg_req.wr)
        begin
            case (reg_req.addr)
                ADDR_ID:   reg_rdata <= ID_VALUE;
                ADDR_ERR:  reg_rdata <= err_q;
                ADDR_SYS1: reg_rdata <= sys1_q;
                ADDR_FMT:  reg_rdata <= fmt_q;
                ADDR_SYS2: reg_rdata <= sys2_q;
                ADDR_MUTE: reg_rdata <= mute_q;
                default:   reg_rdata <= {7'h00, mclk_unused & 1'b0};
            endcase
        end
    end

    assign ctrl.dc_block = sys1_q[BIT_DCBLOCK];
    assign ctrl.hard_unmute = sys1_q[BIT_HARDUNM];
    assign ctrl.deemph = sys1_q[1:0];
    assign ctrl.fmt = fmt_q[3:0];
    assign ctrl.shutdown = sys2_q[BIT_SHUTDOWN];
    assign ctrl.ternary = sys2_q[BIT_TERNARY];
    assign ctrl.fault_out = sys2_q[BIT_FAULTDIR];

    // fault pin: driven low-active enable only when configured as output
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            fault_pin_out <= 1'b1;
            fault_pin_oe_n <= 1'b1;
        end
        else
        begin
            fault_pin_oe_n <= !sys2_q[BIT_FAULTDIR];
            fault_pin_out <= !(|err_q[BIT_PROT +: 1] || fault_pin_in & 1'b0);
        end
    end

    // recovery ramp after clock error: soft walks 512 steps, hard jumps
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            ramp_q <= 12'h000;
        else if (clock_error || sys2_q[BIT_SHUTDOWN])
            ramp_q <= 12'h000;
        else if (sys1_q[BIT_HARDUNM])
            ramp_q <= RAMP_STEPS;
        else if (ramp_q != RAMP_STEPS && lr_rise)
            ramp_q <= ramp_q + 12'h001;
    end
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            volume_scale <= 8'h00;
        else
            volume_scale <= ramp_q[9:2] | {8{ramp_q == RAMP_STEPS}};
    end

    // half-duty square wave shared by muted channels
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            pwm_q <= 4'h0;
        else if (pwm_q == PWM_PERIOD - 4'h1)
            pwm_q <= 4'h0;
        else
            pwm_q <= pwm_q + 4'h1;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_mute
            always_ff @(posedge core_clk)
            begin
                if (sys_rst)
                    mute_pwm[g] <= 1'b0;
                else
                    mute_pwm[g] <= mute_q[g] && (pwm_q < (PWM_PERIOD >> 1));
            end
        end
    endgenerate

    property p_err_sticky;
        @(posedge core_clk) disable iff (sys_rst)
        ($past(err_q[BIT_CLIP]) && !$past(wr_hit(reg_req, reg_en, ADDR_ERR))) |-> err_q[BIT_CLIP];
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error flag lost");

    property p_clip_set;
        @(posedge core_clk) disable iff (sys_rst)
        clip_event |=> err_q[BIT_CLIP];
    endproperty
    a_clip_set: assert property (p_clip_set) else $error("clip not flagged");

    property p_mclk_set;
        @(posedge core_clk) disable iff (sys_rst)
        mclk_err |=> err_q[BIT_MCLK];
    endproperty
    a_mclk_set: assert property (p_mclk_set) else $error("mclk fault not flagged");

    property p_sclk_set;
        @(posedge core_clk) disable iff (sys_rst)
        sclk_err |=> err_q[BIT_SCLK];
    endproperty
    a_sclk_set: assert property (p_sclk_set) else $error("sclk fault not flagged");

    property p_fmt_reserved;
        @(posedge core_clk) disable iff (sys_rst)
        fmt_q[7:0] <= {4'h0, FMT_LAST};
    endproperty
    a_fmt_reserved: assert property (p_fmt_reserved) else $error("bad format code");

    property p_fault_dir;
        @(posedge core_clk) disable iff (sys_rst)
        ##1 (fault_pin_oe_n == !$past(sys2_q[BIT_FAULTDIR]));
    endproperty
    a_fault_dir: assert property (p_fault_dir) else $error("fault pin direction wrong");

    property p_mute_duty;
        @(posedge core_clk) disable iff (sys_rst)
        (mute_q[0] && pwm_q == 4'h0) ##1 mute_q[0] [*4] |-> ##1 !mute_pwm[0];
    endproperty
    a_mute_duty: assert property (p_mute_duty) else $error("mute duty wrong");

    property p_unmuted_quiet;
        @(posedge core_clk) disable iff (sys_rst)
        !$past(mute_q[1]) |-> !mute_pwm[1];
    endproperty
    a_unmuted_quiet: assert property (p_unmuted_quiet) else $error("unmuted channel toggles");
endmodule

//--- tb/host_model.sv
module host_model
    import amp_regs_pkg::*;
(
    input  wire logic       core_clk,
    output logic            reg_en,
    output reg_req_t        reg_req,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        reg_en  = 1'b0;
        reg_req = '0;
    end

    // caller enters just after a rising edge; one idle cycle follows every access
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
        reg_en  = 1'b1;
        reg_req = '{wr, addr, wdata};
        @(posedge core_clk);
        #1;
        rdata   = reg_rdata;
        reg_en  = 1'b0;
        // released request lines show the inverse of the last request, never its value
        reg_req = ~reg_req;
        @(posedge core_clk);
        #1;
    endtask

    // wdata goes out as given; reserved bits are not cleared
    task automatic wr(input logic [7:0] addr, input logic [7:0] wdata);
        logic [7:0] d;
        xfer(1'b1, addr, wdata, d);
    endtask

    // ternary bring-up while still in shutdown; delay and mux places sit outside this block
    task automatic ternary_setup();
        wr(ADDR_SYS2, 8'h48);
        wr(8'h11, 8'h80);
        wr(8'h12, 8'h7c);
        wr(8'h13, 8'h80);
        wr(8'h14, 8'h7c);
        wr(8'h20, 8'h00);
        wr(8'h20, 8'h89);
        wr(8'h20, 8'h77);
        wr(8'h20, 8'h72);
    endtask
endmodule

//--- tb/tb.sv
module tb
    import amp_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic              core_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              reg_en;
    reg_req_t          reg_req;
    logic [7:0]        reg_rdata;
    logic              mclk_pin = 1'b0;
    logic              sclk_pin = 1'b0;
    logic              lrclk_pin = 1'b0;
    logic              pll_unlock = 1'b0;
    logic              clip_event = 1'b0;
    logic              protect_event = 1'b0;
    logic              clock_error = 1'b0;
    logic              fault_pin_out;
    logic              fault_pin_oe_n;
    ctrl_t             ctrl;
    logic [7:0]        volume_scale;
    logic [NUM_CH-1:0] mute_pwm;
    int                n_mismatch = 0;
    int                samples_checked = 0;

    always #2 core_clk = ~core_clk;

    amp_control_status_regs amp_control_status_regs_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_en(reg_en), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .mclk_pin(mclk_pin), .sclk_pin(sclk_pin),
        .lrclk_pin(lrclk_pin), .pll_unlock(pll_unlock), .clip_event(clip_event),
        .protect_event(protect_event), .clock_error(clock_error), .fault_pin_in(1'b0),
        .fault_pin_out(fault_pin_out), .fault_pin_oe_n(fault_pin_oe_n), .ctrl(ctrl),
        .volume_scale(volume_scale), .mute_pwm(mute_pwm));

    host_model host_model_inst (
        .core_clk(core_clk), .reg_en(reg_en), .reg_req(reg_req), .reg_rdata(reg_rdata));

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host_model_inst.xfer(1'b0, addr, 8'h00, d);
        chk8(d, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // n bit clocks per half frame, four core cycles per bit clock, two master clocks each
    task automatic frame(input int n);
        for (int i = 0; i < 8 * n; i++)
        begin
            lrclk_pin = (i < 4 * n);
            sclk_pin  = (i % 4) < 2;
            mclk_pin  = (i % 2) == 0;
            cyc(1);
        end
        {lrclk_pin, sclk_pin, mclk_pin} = 3'b000;
    endtask

    task automatic t_reset();
        chk8({ctrl.dc_block, ctrl.hard_unmute, ctrl.deemph, ctrl.fmt}, 8'h85);
        chk8({3'b000, ctrl.shutdown, ctrl.ternary, ctrl.fault_out, fault_pin_oe_n,
              fault_pin_out}, 8'h13);
        chk8(volume_scale, 8'h00);
        rd(ADDR_ID, ID_VALUE);
        rd(ADDR_ERR, 8'h00);
        rd(ADDR_SYS1, 8'h80);
        rd(ADDR_FMT, 8'h05);
        rd(ADDR_SYS2, 8'h40);
        rd(ADDR_MUTE, 8'h00);
        rd(8'h07, 8'h00);
        host_model_inst.wr(ADDR_ID, 8'hff);
        rd(ADDR_ID, ID_VALUE);
    endtask

    task automatic t_sticky();
        {pll_unlock, clip_event, protect_event} = 3'b111;
        cyc(1);
        {pll_unlock, clip_event, protect_event} = 3'b000;
        host_model_inst.wr(ADDR_SYS2, 8'h42);
        cyc(20);
        rd(ADDR_ERR, 8'h46);
        chk8({6'h00, fault_pin_oe_n, fault_pin_out}, 8'h00);
        // a written one keeps the flag but cannot raise a clear one
        host_model_inst.wr(ADDR_ERR, 8'hff);
        rd(ADDR_ERR, 8'h46);
        host_model_inst.wr(ADDR_ERR, 8'h00);
        rd(ADDR_ERR, 8'h00);
        chk8({7'h00, fault_pin_out}, 8'h01);
    endtask

    task automatic t_format();
        for (int c = 0; c < 16; c++)
        begin
            host_model_inst.wr(ADDR_FMT, 8'(c));
            rd(ADDR_FMT, (c <= 8) ? 8'(c) : 8'h08);
            chk8({4'h0, ctrl.fmt}, (c <= 8) ? 8'(c) : 8'h08);
        end
    endtask

    task automatic t_sys1();
        for (int c = 0; c < 4; c++)
        begin
            host_model_inst.wr(ADDR_SYS1, 8'h80 | 8'(c));
            chk8({6'h00, ctrl.deemph}, 8'(c));
        end
        host_model_inst.wr(ADDR_SYS1, 8'hff);
        rd(ADDR_SYS1, 8'ha3);
        host_model_inst.wr(ADDR_SYS1, 8'h20);
        chk8({6'h00, ctrl.dc_block, ctrl.hard_unmute}, 8'h01);
        // shutdown holds the ramp at zero, so leave it first
        host_model_inst.wr(ADDR_SYS2, 8'h00);
        clock_error = 1'b1;
        cyc(3);
        chk8(volume_scale, 8'h00);
        clock_error = 1'b0;
        cyc(3);
        chk8(volume_scale, 8'hff);
        // soft unmute steps only on frame edges, none arrive here
        host_model_inst.wr(ADDR_SYS1, 8'h80);
        clock_error = 1'b1;
        cyc(3);
        clock_error = 1'b0;
        cyc(3);
        chk8(volume_scale, 8'h00);
    endtask

    task automatic t_sys2();
        host_model_inst.ternary_setup();
        host_model_inst.wr(ADDR_SYS2, 8'h08);
        rd(ADDR_SYS2, 8'h08);
        chk8({6'h00, ctrl.shutdown, ctrl.ternary}, 8'h01);
        host_model_inst.wr(ADDR_SYS2, 8'hff);
        rd(ADDR_SYS2, 8'hca);
    endtask

    task automatic t_mute();
        int hi [NUM_CH];
        host_model_inst.wr(ADDR_MUTE, 8'h05);
        hi = '{default: 0};
        for (int i = 0; i < 16; i++)
        begin
            for (int c = 0; c < NUM_CH; c++)
                hi[c] += int'(mute_pwm[c] === 1'b1);
            cyc(1);
        end
        chk8(8'(hi[0]), 8'h08);
        chk8(8'(hi[1]), 8'h00);
        chk8(8'(hi[2]), 8'h08);
        host_model_inst.wr(ADDR_MUTE, 8'hff);
        rd(ADDR_MUTE, 8'h07);
    endtask

    task automatic t_clocks();
        host_model_inst.wr(ADDR_SYS2, 8'h00);
        // the host talks while the link keeps running, so no frame is stretched
        fork
            repeat (7) frame(8);
            begin
                cyc(200);
                host_model_inst.wr(ADDR_ERR, 8'h00);
                cyc(200);
                rd(ADDR_ERR, 8'h00);
            end
        join
        // seven frame edges of soft ramp, four steps per volume code
        chk8(volume_scale, 8'h01);
        frame(6);
        frame(8);
        rd(ADDR_ERR, 8'hb8);
        repeat (2) frame(8);
        rd(ADDR_ERR, 8'hb8);
    endtask

    // the longest path is well under ten thousand cycles
    initial
    begin
        #(40000 * 4);
        n_mismatch++;
        final_report();
    end

    initial
    begin
        cyc(2);
        sys_rst = 1'b0;
        t_reset();
        t_sticky();
        t_format();
        t_sys1();
        t_sys2();
        t_mute();
        t_clocks();
        final_report();
    end
endmodule
